// >>> src/modulo_params.svh
`ifndef MODULO_PARAMS_SVH
`define MODULO_PARAMS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define MAC_ADDR_W 16
`define MAC_REG_W 4
`define MAC_BREV_W 15

// ----------------------------------------
// fixed values
// ----------------------------------------
// the stack pointer can never be a bit-reversed pointer
`define MAC_STACK_REG 4'hf
`define MAC_ADDR_ZERO 16'h0000
`define MAC_ADDR_ONE 16'h0001

`endif

// >>> src/modulo_pkg.sv
`include "modulo_params.svh"

package modulo_pkg;

  // ----------------------------------------
  // addressing modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    mode_indirect,
    mode_post_modify,
    mode_pre_modify,
    mode_reg_offset
  } addr_mode_e;

  typedef logic [`MAC_ADDR_W-1:0] addr_t;
  typedef logic [`MAC_REG_W-1:0] wreg_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  // one address computation from decode
  typedef struct packed {
    logic valid;
    wreg_t wreg;
    addr_mode_e mode;
    logic write;
    logic word;
    addr_t base;
    addr_t step;
  } agen_req_s;

  typedef struct packed {
    logic enable;
    wreg_t wsel;
    addr_t start_addr;
    addr_t end_addr;
  } modulo_cfg_s;

  typedef struct packed {
    logic enable;
    wreg_t wsel;
    logic [`MAC_BREV_W-1:0] modifier;
  } brev_cfg_s;

  // address towards data memory
  typedef struct packed {
    logic valid;
    addr_t effective_address;
    logic wrapped;
    logic reversed;
  } access_s;

  // pointer update towards the register file
  typedef struct packed {
    logic valid;
    wreg_t wreg;
    addr_t value;
  } writeback_s;

endpackage

// >>> src/modulo_wrap.sv
`timescale 1ns/1ps
`include "modulo_params.svh"

module modulo_wrap (
  // candidate address and direction
  input wire logic [`MAC_ADDR_W-1:0] addr_in,
  input wire logic apply,
  input wire logic up,
  // buffer limits
  input wire logic [`MAC_ADDR_W-1:0] start_addr,
  input wire logic [`MAC_ADDR_W-1:0] end_addr,
  // corrected address
  output logic [`MAC_ADDR_W-1:0] addr_out,
  output logic wrapped
);

  // ----------------------------------------
  // boundary test and fold-back
  // ----------------------------------------
  // magnitude compare, not equality, so large steps still fold correctly
  always_comb begin
    addr_out = addr_in;
    wrapped = 1'b0;
    if (apply && up && (addr_in > end_addr)) begin
      addr_out = start_addr + (addr_in - end_addr - `MAC_ADDR_ONE);
      wrapped = 1'b1;
    end else if (apply && !up && (addr_in < start_addr)) begin
      addr_out = end_addr - (start_addr - addr_in - `MAC_ADDR_ONE);
      wrapped = 1'b1;
    end
  end

endmodule

// >>> src/modulo_address_correction.sv
`timescale 1ns/1ps
`include "modulo_params.svh"

// Behaviour
// - modulo correction usable on any working register
// - incrementing buffers compare against upper boundary
// - decrementing buffers compare against lower boundary
// - beyond-boundary addresses wrap, not only equality
// - pointer written back only for pre/post-modify
// - register offset: corrected access, pointer unchanged
// - bit-reversed writes take precedence over modulo

module modulo_address_correction (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // request from decode
  input wire modulo_pkg::agen_req_s req,
  // configuration
  input wire modulo_pkg::modulo_cfg_s mod_cfg,
  input wire modulo_pkg::brev_cfg_s brev_cfg,
  // results
  output modulo_pkg::access_s access_q,
  output modulo_pkg::writeback_s wb_q
);

  // ----------------------------------------
  // address arithmetic
  // ----------------------------------------
  modulo_pkg::addr_t sum;
  modulo_pkg::addr_t wrap_addr;
  modulo_pkg::addr_t mod_byte;
  modulo_pkg::addr_t rev_base;
  modulo_pkg::addr_t rev_mod;
  modulo_pkg::addr_t rev_sum;
  modulo_pkg::addr_t brev_addr;
  logic up;
  logic down;
  logic mod_hit;
  logic br_hit;
  logic wrapped;
  logic modify;

  // signed step: positive walks up, negative walks down, zero leaves alone
  assign sum = req.base + req.step;
  assign up = !req.step[`MAC_ADDR_W-1] && (req.step != `MAC_ADDR_ZERO);
  assign down = req.step[`MAC_ADDR_W-1];
  assign modify = (req.mode == modulo_pkg::mode_post_modify) ||
                  (req.mode == modulo_pkg::mode_pre_modify);

  // any working register may be the modulo pointer
  assign mod_hit = mod_cfg.enable && (req.wreg == mod_cfg.wsel) &&
                   (req.mode != modulo_pkg::mode_indirect) && (up || down);

  // reversed carry only for word writes with increment modes
  assign br_hit = brev_cfg.enable && (req.wreg == brev_cfg.wsel) &&
                  (brev_cfg.wsel != `MAC_STACK_REG) && req.write && req.word &&
                  modify && up;

  // modifier is held in words, scaled to bytes
  assign mod_byte = {brev_cfg.modifier, 1'b0};

  modulo_wrap u_wrap (
    .addr_in(sum),
    .apply(mod_hit),
    .up(up),
    .start_addr(mod_cfg.start_addr),
    .end_addr(mod_cfg.end_addr),
    .addr_out(wrap_addr),
    .wrapped(wrapped)
  );

  // ----------------------------------------
  // bit reversal
  // ----------------------------------------
  // reverse, add, reverse back: carry travels from msb to lsb
  modulo_pkg::addr_t rev_add;
  assign rev_add = rev_base + rev_mod;

  genvar i;
  generate
    for (i = 0; i < `MAC_ADDR_W; i = i + 1) begin : g_rev
      assign rev_base[i] = req.base[`MAC_ADDR_W-1-i];
      assign rev_mod[i] = mod_byte[`MAC_ADDR_W-1-i];
      assign rev_sum[i] = rev_add[`MAC_ADDR_W-1-i];
    end
  endgenerate

  // word data only, so the byte bit is forced clear
  assign brev_addr = {rev_sum[`MAC_ADDR_W-1:1], 1'b0};

  // ----------------------------------------
  // next outputs
  // ----------------------------------------
  modulo_pkg::access_s access_d;
  modulo_pkg::writeback_s wb_d;
  modulo_pkg::addr_t next_addr;

  // next access and pointer update, all from one request
  always_comb begin
    next_addr = br_hit ? brev_addr : wrap_addr;
    access_d.valid = req.valid;
    access_d.wrapped = req.valid && wrapped && !br_hit;
    access_d.reversed = req.valid && br_hit;
    access_d.effective_address = req.base;
    unique case (req.mode)
      modulo_pkg::mode_indirect: access_d.effective_address = req.base;
      modulo_pkg::mode_post_modify: access_d.effective_address = req.base;
      modulo_pkg::mode_pre_modify: access_d.effective_address = next_addr;
      modulo_pkg::mode_reg_offset: access_d.effective_address = next_addr;
    endcase
    // offset and plain indirect never touch the pointer
    wb_d.valid = req.valid && modify;
    wb_d.wreg = req.wreg;
    wb_d.value = next_addr;
  end

  // outputs straight from flops; reset clears both one-cycle pulses
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      access_q <= '0;
      wb_q <= '0;
    end else begin
      access_q <= access_d;
      wb_q <= wb_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence seq_inc_overshoot;
    req.valid && mod_hit && up && !br_hit && modify && (sum > mod_cfg.end_addr);
  endsequence

  sequence seq_dec_overshoot;
    req.valid && mod_hit && down && !br_hit && modify && (sum < mod_cfg.start_addr);
  endsequence

  sequence seq_offset_overshoot;
    req.valid && mod_hit && up && (req.mode == modulo_pkg::mode_reg_offset) &&
      (sum > mod_cfg.end_addr);
  endsequence

  a_access_latency: assert property (@(posedge clock) disable iff (!rst_b)
    req.valid |=> access_q.valid)
    else $error("access not issued one cycle after request");

  a_wb_only_modify: assert property (@(posedge clock) disable iff (!rst_b)
    wb_q.valid |-> $past(req.valid) &&
      ($past(req.mode) inside {modulo_pkg::mode_post_modify, modulo_pkg::mode_pre_modify}))
    else $error("pointer written back outside pre/post modify");

  a_offset_keeps_ptr: assert property (@(posedge clock) disable iff (!rst_b)
    req.valid && (req.mode == modulo_pkg::mode_reg_offset) |=> !wb_q.valid)
    else $error("register offset mode updated the pointer");

  a_inc_overshoot: assert property (@(posedge clock) disable iff (!rst_b)
    seq_inc_overshoot |=> wb_q.valid && (wb_q.value ==
      $past(mod_cfg.start_addr) + ($past(sum) - $past(mod_cfg.end_addr) - 16'h0001)))
    else $error("incrementing overshoot folded to wrong address");

  a_dec_overshoot: assert property (@(posedge clock) disable iff (!rst_b)
    seq_dec_overshoot |=> wb_q.valid && (wb_q.value ==
      $past(mod_cfg.end_addr) - ($past(mod_cfg.start_addr) - $past(sum) - 16'h0001)))
    else $error("decrementing overshoot folded to wrong address");

  a_inc_in_range: assert property (@(posedge clock) disable iff (!rst_b)
    req.valid && mod_hit && up && !br_hit && modify &&
      (req.base >= mod_cfg.start_addr) && (req.base <= mod_cfg.end_addr) &&
      (req.step <= mod_cfg.end_addr - mod_cfg.start_addr) && (sum >= req.base)
    |=> (wb_q.value >= $past(mod_cfg.start_addr)) && (wb_q.value <= $past(mod_cfg.end_addr)))
    else $error("incrementing pointer left its buffer");

  a_bitrev_wins: assert property (@(posedge clock) disable iff (!rst_b)
    req.valid && br_hit |=> access_q.reversed && !access_q.wrapped &&
      (wb_q.value[0] == 1'b0))
    else $error("bit-reversed write did not take precedence");

  a_any_reg_wrap: assert property (@(posedge clock) disable iff (!rst_b)
    seq_inc_overshoot |=> access_q.wrapped && (wb_q.wreg == $past(mod_cfg.wsel)))
    else $error("modulo wrap missed on selected register");

  a_post_uses_base: assert property (@(posedge clock) disable iff (!rst_b)
    req.valid && (req.mode == modulo_pkg::mode_post_modify)
    |=> access_q.effective_address == $past(req.base))
    else $error("post-modify access did not use the old pointer");

  // a step no larger than the buffer can never leave it when walking down
  a_dec_in_range: assert property (@(posedge clock) disable iff (!rst_b)
    req.valid && mod_hit && down && !br_hit && modify &&
      (req.base >= mod_cfg.start_addr) && (req.base <= mod_cfg.end_addr) &&
      ((16'h0000 - req.step) <= mod_cfg.end_addr - mod_cfg.start_addr) && (sum <= req.base)
    |=> (wb_q.value >= $past(mod_cfg.start_addr)) && (wb_q.value <= $past(mod_cfg.end_addr)))
    else $error("decrementing pointer left its buffer");

  a_offset_wraps: assert property (@(posedge clock) disable iff (!rst_b)
    seq_offset_overshoot |=> access_q.wrapped && !wb_q.valid &&
      (access_q.effective_address ==
      $past(mod_cfg.start_addr) + ($past(sum) - $past(mod_cfg.end_addr) - 16'h0001)))
    else $error("register offset access not folded");

  a_inside_untouched: assert property (@(posedge clock) disable iff (!rst_b)
    req.valid && mod_hit && !br_hit && (req.mode != modulo_pkg::mode_post_modify) &&
      (sum >= mod_cfg.start_addr) && (sum <= mod_cfg.end_addr)
    |=> !access_q.wrapped && (access_q.effective_address == $past(sum)))
    else $error("address inside the buffer was folded");

  a_indirect_plain: assert property (@(posedge clock) disable iff (!rst_b)
    req.valid && (req.mode == modulo_pkg::mode_indirect)
    |=> !access_q.wrapped && !wb_q.valid && (access_q.effective_address == $past(req.base)))
    else $error("plain indirect access was modified");

  a_valid_drops: assert property (@(posedge clock) disable iff (!rst_b)
    !req.valid |=> !access_q.valid && !wb_q.valid)
    else $error("answer stood longer than one cycle");

  a_no_reverse_read: assert property (@(posedge clock) disable iff (!rst_b)
    req.valid && (!req.write || !req.word || (req.wreg == `MAC_STACK_REG))
    |=> !access_q.reversed)
    else $error("bit reversal applied outside word writes");

endmodule

// >>> dv/decode_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// decode and operand fetch side
// ----------------------------------------
module decode_model (
  // clock
  input wire logic clock,
  // towards the block
  output modulo_pkg::agen_req_s req,
  // answers from the block
  input wire modulo_pkg::access_s access_q,
  input wire modulo_pkg::writeback_s wb_q
);
  initial req = '0;

  // one request per call; released fields are scrambled so stale values never help
  task automatic send(input modulo_pkg::agen_req_s r, output modulo_pkg::access_s a,
    output modulo_pkg::writeback_s w);
    @(posedge clock);
    req <= r;
    @(posedge clock);
    req <= {1'b0, ~r[$bits(r)-2:0]};
    #1;
    a = access_q;
    w = wb_q;
  endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps

// ----------------------------------------
// bench top
// ----------------------------------------
module tb_top;
  logic clock;
  logic rst_b;
  modulo_pkg::agen_req_s req;
  modulo_pkg::modulo_cfg_s mod_cfg;
  modulo_pkg::brev_cfg_s brev_cfg;
  modulo_pkg::access_s a;
  modulo_pkg::access_s access_q;
  modulo_pkg::writeback_s w;
  modulo_pkg::writeback_s wb_q;
  int fail_count;
  int samples_checked;
  int cycles;

  modulo_address_correction u_dut (.clock(clock), .rst_b(rst_b), .req(req),
    .mod_cfg(mod_cfg), .brev_cfg(brev_cfg), .access_q(access_q), .wb_q(wb_q));
  decode_model u_decode (.clock(clock), .req(req), .access_q(access_q), .wb_q(wb_q));

  // 250 MHz core clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 80 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      complete_run();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic set_mod(input logic [3:0] wsel, input logic [15:0] s, input logic [15:0] e);
    @(posedge clock);
    mod_cfg <= '{1'b1, wsel, s, e};
  endtask

  task automatic go(input logic [3:0] wreg, input modulo_pkg::addr_mode_e m,
    input logic wr, input logic [15:0] base, input logic [15:0] step);
    u_decode.send('{1'b1, wreg, m, wr, 1'b1, base, step}, a, w);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // increment overshooting the end by more than one address
  task automatic sc_up_overshoot();
    set_mod(4'h5, 16'h1000, 16'h10ff);
    go(4'h5, modulo_pkg::mode_pre_modify, 1'b0, 16'h10fe, 16'h0004);
    check("up ea", a.effective_address, 16'h1002);
    check("up wrap", {15'h0, a.wrapped}, 16'h0001);
    check("up wb", w.value, 16'h1002);
    check("up wb valid", {15'h0, w.valid}, 16'h0001);
    check("up valid", {15'h0, a.valid}, 16'h0001);
  endtask

  // decrement below the start, post-modify keeps the old address for the access
  task automatic sc_down_post();
    go(4'h5, modulo_pkg::mode_post_modify, 1'b0, 16'h1000, 16'hfffe);
    check("down ea", a.effective_address, 16'h1000);
    check("down wb", w.value, 16'h10fe);
    check("down wreg", {12'h0, w.wreg}, 16'h0005);
  endtask

  // register offset: access corrected, pointer left alone
  task automatic sc_offset();
    go(4'h5, modulo_pkg::mode_reg_offset, 1'b0, 16'h10fe, 16'h0002);
    check("ofs ea", a.effective_address, 16'h1000);
    check("ofs wb valid", {15'h0, w.valid}, 16'h0000);
    go(4'h5, modulo_pkg::mode_indirect, 1'b0, 16'h10fe, 16'h0002);
    check("ind wb valid", {15'h0, w.valid}, 16'h0000);
    check("ind ea", a.effective_address, 16'h10fe);
  endtask

  // landing exactly on either limit stays inside; answers stand one cycle only
  task automatic sc_edge();
    go(4'h5, modulo_pkg::mode_pre_modify, 1'b0, 16'h10fe, 16'h0001);
    check("end ea", a.effective_address, 16'h10ff);
    check("end wrap", {15'h0, a.wrapped}, 16'h0000);
    go(4'h5, modulo_pkg::mode_pre_modify, 1'b0, 16'h1002, 16'hfffe);
    check("start ea", a.effective_address, 16'h1000);
    check("start wrap", {15'h0, a.wrapped}, 16'h0000);
    @(posedge clock);
    #1;
    check("drop access", {15'h0, access_q.valid}, 16'h0000);
    check("drop wb", {15'h0, wb_q.valid}, 16'h0000);
  endtask

  // reset in mid-run clears both outputs; the first request after release is served
  task automatic sc_reset();
    go(4'h5, modulo_pkg::mode_pre_modify, 1'b0, 16'h10fe, 16'h0004);
    @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    #1;
    check("rst ea", access_q.effective_address, 16'h0000);
    check("rst wb", wb_q.value, 16'h0000);
    @(posedge clock);
    rst_b <= 1'b1;
    go(4'h5, modulo_pkg::mode_post_modify, 1'b0, 16'h1000, 16'hfffe);
    check("rst valid", {15'h0, a.valid}, 16'h0001);
    check("rst wb after", w.value, 16'h10fe);
  endtask

  // every working register, landing exactly on the end boundary plus one
  task automatic sc_all_regs();
    for (int i = 0; i < 16; i++) begin
      set_mod(i[3:0], 16'h1000, 16'h10ff);
      go(i[3:0], modulo_pkg::mode_pre_modify, 1'b0, 16'h10ff, 16'h0001);
      check("reg ea", a.effective_address, 16'h1000);
      check("reg wb", {12'h0, w.wreg}, {12'h0, i[3:0]});
    end
  endtask

  // bit-reversed write wins over modulo on the same register, a read does not
  task automatic sc_brev();
    set_mod(4'h3, 16'h1000, 16'h100f);
    brev_cfg <= '{1'b1, 4'h3, 15'h0008};
    go(4'h3, modulo_pkg::mode_pre_modify, 1'b1, 16'h1000, 16'h0002);
    check("brev ea", a.effective_address, 16'h1010);
    check("brev flags", {14'h0, a.wrapped, a.reversed}, 16'h0001);
    go(4'h3, modulo_pkg::mode_pre_modify, 1'b0, 16'h100e, 16'h0004);
    check("read ea", a.effective_address, 16'h1002);
    check("read flags", {14'h0, a.wrapped, a.reversed}, 16'h0002);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    mod_cfg = '0;
    brev_cfg = '0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    sc_up_overshoot();
    sc_down_post();
    sc_offset();
    sc_edge();
    sc_reset();
    sc_all_regs();
    sc_brev();
    complete_run();
  end
endmodule
